// file: hw/pwrrg_regs.sv
/*
  power enable and soft reset register bank behind an apb slave.
  assumes: apb master in pclk domain, 32-bit data, byte address is four
  times the register index; analogue blocks consume the enable outputs.
*/
`timescale 1ns/1ns
`include "pwrrg_params.svh"

// What this block does
// - A two-bit mid-rail divider select resets to off and picks off, normal, standby or fast.
// - One normal-bias enable bit resets to off and turns on the shared bias generator.
// - With thermal shutdown and sensor both enabled, over-temperature turns audio outputs off.
// - The thermal sensor enable sits at bit 7 of power management and resets to one.
// - Line out bit 4, speaker gain bit 2, speaker bit 1 and converter bit 0 reset to off.
// - The output clock enable drives a divided clock onto the master clock pin.
// - The timeout clock enable starts the slow timeout clock.
// - Processing clock bit 1 and system clock bit 0 of clock control three reset to off.
// - Loop bit 0, range compressor bit 15, sequencer bit 15 and equaliser bit 0 reset to off.
// - Any write to register zero returns every register to its default.
// - A read of register zero returns the fixed identification code.
module pwrrg_regs #(
  parameter logic [15:0] DEVICE_ID  = 16'hA5C3, // arbitrary value
  parameter int          TO_DIV     = 1000,
  parameter int          OPDIV_W    = `PWRRG_OPDIV_W
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire pwrrg_pkg::pwrrg_apb_req_s apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic [OPDIV_W-1:0]    output_clock_divider,
  input  wire logic                  over_temp,
  output pwrrg_pkg::pwrrg_ctrl_s     ctrl,
  output logic                       audio_out_allowed,
  output logic                       divided_output_clock,
  output logic                       divided_output_clock_oe,
  output logic                       slow_timeout_clock
);
  import pwrrg_pkg::*;

  localparam int NREG = 8;

  // ============================================================
  // address decode
  logic [7:0]  idx;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit_id;
  logic [NREG-1:0] hit;
  logic [7:0]  idx_tab   [NREG];
  logic [15:0] mask_tab  [NREG];
  logic [15:0] rstv_tab  [NREG];

  assign idx_tab[0]  = `PWRRG_IDX_MIDRAIL;
  assign idx_tab[1]  = `PWRRG_IDX_BIAS;
  assign idx_tab[2]  = `PWRRG_IDX_PWRMGT;
  assign idx_tab[3]  = `PWRRG_IDX_CLK3;
  assign idx_tab[4]  = `PWRRG_IDX_LOOP;
  assign idx_tab[5]  = `PWRRG_IDX_DRC;
  assign idx_tab[6]  = `PWRRG_IDX_WSEQ;
  assign idx_tab[7]  = `PWRRG_IDX_EQ;
  assign mask_tab[0] = `PWRRG_MASK_MIDRAIL;
  assign mask_tab[1] = `PWRRG_MASK_BIAS;
  assign mask_tab[2] = `PWRRG_MASK_PWRMGT;
  assign mask_tab[3] = `PWRRG_MASK_CLK3;
  assign mask_tab[4] = `PWRRG_MASK_LOOP;
  assign mask_tab[5] = `PWRRG_MASK_DRC;
  assign mask_tab[6] = `PWRRG_MASK_WSEQ;
  assign mask_tab[7] = `PWRRG_MASK_EQ;
  assign rstv_tab[0] = `PWRRG_RST_OTHER;
  assign rstv_tab[1] = `PWRRG_RST_OTHER;
  assign rstv_tab[2] = `PWRRG_RST_PWRMGT;
  assign rstv_tab[3] = `PWRRG_RST_OTHER;
  assign rstv_tab[4] = `PWRRG_RST_OTHER;
  assign rstv_tab[5] = `PWRRG_RST_OTHER;
  assign rstv_tab[6] = `PWRRG_RST_OTHER;
  assign rstv_tab[7] = `PWRRG_RST_OTHER;

  // high bits beyond the map must be zero, else the access misses
  assign idx    = apb_req.paddr[9:2];
  assign acc    = apb_req.psel && apb_req.penable;
  assign wr     = acc && apb_req.pwrite;
  assign rd     = acc && !apb_req.pwrite;
  assign hit_id = (idx == `PWRRG_IDX_RST_ID) && (apb_req.paddr[11:10] == 2'h0)
                  && (apb_req.paddr[1:0] == 2'h0);

  // ============================================================
  // register storage, one entry per mapped register
  logic [15:0] reg_q    [NREG];
  logic [15:0] reg_next [NREG];
  logic        soft_rst;

  assign soft_rst = wr && hit_id;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = (idx == idx_tab[g]) && (apb_req.paddr[11:10] == 2'h0)
                      && (apb_req.paddr[1:0] == 2'h0);

      always_comb begin
        reg_next[g] = reg_q[g];
        if (soft_rst) begin
          reg_next[g] = rstv_tab[g];
        end else if (wr && hit[g]) begin
          reg_next[g] = apb_req.pwdata[15:0] & mask_tab[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reg_q[g] <= (g == 2) ? `PWRRG_RST_PWRMGT : `PWRRG_RST_OTHER;
        end else begin
          reg_q[g] <= reg_next[g];
        end
      end
    end
  endgenerate

  // ============================================================
  // read data and response: zero wait states
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  always_comb begin
    rdata_next = rdata_reg;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      rdata_next = 32'h0000_0000;
      if (hit_id) begin
        rdata_next = {16'h0000, DEVICE_ID};
      end
      for (int i = 0; i < NREG; i++) begin
        if (hit[i]) begin
          rdata_next = {16'h0000, reg_q[i]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // unmapped addresses answer with an error and read zero
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = acc && !(hit_id || (|hit));

  // ============================================================
  // field extraction
  assign ctrl.midrail_divider_select = pwrrg_mid_e'(reg_q[0][`PWRRG_MID_SEL_LO +: 2]);
  assign ctrl.normal_bias_enable        = reg_q[1][`PWRRG_BIAS_EN_BIT];
  assign ctrl.thermal_shutdown_enable   = reg_q[2][`PWRRG_TSHUT_BIT];
  assign ctrl.thermal_sensor_enable     = reg_q[2][`PWRRG_TSENSE_BIT];
  assign ctrl.line_output_enable        = reg_q[2][`PWRRG_LINE_BIT] & audio_out_allowed;
  assign ctrl.speaker_gain_stage_enable = reg_q[2][`PWRRG_SPKPGA_BIT];
  assign ctrl.speaker_output_enable     = reg_q[2][`PWRRG_SPK_BIT] && audio_out_allowed;
  assign ctrl.converter_enable          = reg_q[2][`PWRRG_DAC_BIT];
  assign ctrl.output_clock_enable       = reg_q[3][`PWRRG_CLKOP_BIT];
  assign ctrl.timeout_clock_enable      = reg_q[3][`PWRRG_CLKTO_BIT];
  assign ctrl.processing_clock_enable   = reg_q[3][`PWRRG_CLKDSP_BIT];
  assign ctrl.system_clock_enable       = reg_q[3][`PWRRG_CLKSYS_BIT];
  assign ctrl.locked_loop_enable        = reg_q[4][`PWRRG_LOOP_BIT];
  assign ctrl.range_compressor_enable   = reg_q[5][`PWRRG_DRC_BIT];
  assign ctrl.sequencer_enable          = reg_q[6][`PWRRG_WSEQ_BIT];
  assign ctrl.equaliser_enable          = reg_q[7][`PWRRG_EQ_BIT];

  // ============================================================
  // thermal guard
  logic tripped;

  pwrrg_thermal u_thermal (
    .pclk        (pclk),
    .presetn     (presetn),
    .soft_rst_i  (soft_rst),
    .shut_en_i   (ctrl.thermal_shutdown_enable),
    .sense_en_i  (ctrl.thermal_sensor_enable),
    .over_temp_i (over_temp),
    .tripped_o   (tripped)
  );

  assign audio_out_allowed = !tripped;

  // ============================================================
  // clocks derived as enable pulses from pclk
  logic op_tick;
  logic op_clk_reg;
  logic op_clk_next;

  pwrrg_clkdiv #(.W(OPDIV_W)) u_opdiv (
    .pclk    (pclk),
    .presetn (presetn),
    .run_i   (ctrl.output_clock_enable),
    .div_i   (output_clock_divider),
    .tick_o  (op_tick)
  );

  always_comb begin
    op_clk_next = op_clk_reg;
    if (!ctrl.output_clock_enable) begin
      op_clk_next = 1'b0;
    end else if (op_tick) begin
      op_clk_next = !op_clk_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_clk_reg <= 1'b0;
    end else begin
      op_clk_reg <= op_clk_next;
    end
  end

  assign divided_output_clock    = op_clk_reg;
  assign divided_output_clock_oe = ctrl.output_clock_enable;

  pwrrg_clkdiv #(.W(16)) u_todiv (
    .pclk    (pclk),
    .presetn (presetn),
    .run_i   (ctrl.timeout_clock_enable),
    .div_i   (16'(TO_DIV)),
    .tick_o  (slow_timeout_clock)
  );

  // ============================================================
  // checks
  softrst_pwrmgt_a: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst |=> (reg_q[2] == `PWRRG_RST_PWRMGT) && (reg_q[0] == 16'h0000))
    else $error("soft reset did not restore defaults");

  id_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit_id) |-> prdata == {16'h0000, DEVICE_ID})
    else $error("identification code wrong");

  unused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reg_q[2] & ~`PWRRG_MASK_PWRMGT) == 16'h0000)
    else $error("unassigned bit set");

  midrail_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[0]) |=> ctrl.midrail_divider_select == pwrrg_mid_e'($past(apb_req.pwdata[2:1])))
    else $error("mid-rail select not stored");

  bias_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[1]) |=> ctrl.normal_bias_enable == $past(apb_req.pwdata[1]))
    else $error("bias enable not stored");

  outputs_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    tripped |-> !ctrl.speaker_output_enable && !ctrl.line_output_enable)
    else $error("audio output on while tripped");

  sensor_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[2]) |=> ctrl.thermal_sensor_enable == $past(apb_req.pwdata[7]))
    else $error("sensor enable not stored");

  divided_output_clock_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.output_clock_enable [*2] |-> !divided_output_clock)
    else $error("output clock runs while disabled");

  slow_timeout_clock_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.timeout_clock_enable [*2] |-> !slow_timeout_clock)
    else $error("timeout clock runs while disabled");

  clk3_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[3]) |=> {ctrl.processing_clock_enable, ctrl.system_clock_enable}
                       == $past(apb_req.pwdata[1:0]))
    else $error("clock enables not stored");

  drc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[5]) |=> ctrl.range_compressor_enable == $past(apb_req.pwdata[15]))
    else $error("compressor enable not stored");

  loop_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[4]) |=> ctrl.locked_loop_enable == $past(apb_req.pwdata[0]))
    else $error("loop enable not stored");

  wseq_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[6]) |=> ctrl.sequencer_enable == $past(apb_req.pwdata[15]))
    else $error("sequencer enable not stored");

  eq_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[7]) |=> ctrl.equaliser_enable == $past(apb_req.pwdata[0]))
    else $error("equaliser enable not stored");

  dac_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[2]) |=> {ctrl.speaker_gain_stage_enable, ctrl.converter_enable}
                       == {$past(apb_req.pwdata[2]), $past(apb_req.pwdata[0])})
    else $error("converter or gain enable not stored");

  shut_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[2]) |=> ctrl.thermal_shutdown_enable == $past(apb_req.pwdata[8]))
    else $error("shutdown enable not stored");

  miss_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && !hit_id && !(|hit)) |=> (reg_q[2] == $past(reg_q[2]))
                                   && (reg_q[0] == $past(reg_q[0])))
    else $error("unmapped write changed a register");

  divided_output_clock_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl.output_clock_enable && op_tick) |=> divided_output_clock != $past(divided_output_clock))
    else $error("output clock did not toggle");

endmodule : pwrrg_regs

// file: hw/pwrrg_params.svh
/*
  offsets, field positions, reset values and timing counts for the power
  enable and soft reset register bank.
  assumes: included by bare name from design files only.
*/
`ifndef PWRRG_PARAMS_SVH
`define PWRRG_PARAMS_SVH

// ============================================================
// register indices (printed offsets are not all multiples of four)
`define PWRRG_IDX_RST_ID   8'h00
`define PWRRG_IDX_MIDRAIL  8'h04
`define PWRRG_IDX_BIAS     8'h05
`define PWRRG_IDX_PWRMGT   8'h0B
`define PWRRG_IDX_CLK3     8'h0E
`define PWRRG_IDX_LOOP     8'h10
`define PWRRG_IDX_DRC      8'h20
`define PWRRG_IDX_WSEQ     8'h26
`define PWRRG_IDX_EQ       8'h2A

// ============================================================
// field positions
`define PWRRG_MID_SEL_LO   1
`define PWRRG_BIAS_EN_BIT  1
`define PWRRG_TSHUT_BIT    8
`define PWRRG_TSENSE_BIT   7
`define PWRRG_LINE_BIT     4
`define PWRRG_SPKPGA_BIT   2
`define PWRRG_SPK_BIT      1
`define PWRRG_DAC_BIT      0
`define PWRRG_CLKOP_BIT    5
`define PWRRG_CLKTO_BIT    2
`define PWRRG_CLKDSP_BIT   1
`define PWRRG_CLKSYS_BIT   0
`define PWRRG_LOOP_BIT     0
`define PWRRG_DRC_BIT      15
`define PWRRG_WSEQ_BIT     15
`define PWRRG_EQ_BIT       0

// ============================================================
// implemented-bit masks and reset values
`define PWRRG_MASK_MIDRAIL 16'h0006
`define PWRRG_MASK_BIAS    16'h0002
`define PWRRG_MASK_PWRMGT  16'h0197
`define PWRRG_MASK_CLK3    16'h0027
`define PWRRG_MASK_LOOP    16'h0001
`define PWRRG_MASK_DRC     16'h8000
`define PWRRG_MASK_WSEQ    16'h8000
`define PWRRG_MASK_EQ      16'h0001
`define PWRRG_RST_PWRMGT   16'h0180
`define PWRRG_RST_OTHER    16'h0000

// ============================================================
// timing
`define PWRRG_CLK_NS       20
`define PWRRG_OPDIV_W      4
`define PWRRG_TODIV_DEF    16'h03E8

`endif

// file: hw/pwrrg_pkg.sv
/*
  types for the power enable and soft reset register bank.
  assumes: compiled before every design module of the bank.
*/
package pwrrg_pkg;

  // ============================================================
  // mid-rail reference modes
  typedef enum logic [1:0] {
    PWRRG_MID_OFF  = 2'h0,
    PWRRG_MID_NORM = 2'h1,
    PWRRG_MID_STBY = 2'h2,
    PWRRG_MID_FAST = 2'h3
  } pwrrg_mid_e;

  // ============================================================
  // enables seen by the analogue and clock logic
  typedef struct packed {
    pwrrg_mid_e midrail_divider_select;
    logic       normal_bias_enable;
    logic       thermal_shutdown_enable;
    logic       thermal_sensor_enable;
    logic       line_output_enable;
    logic       speaker_gain_stage_enable;
    logic       speaker_output_enable;
    logic       converter_enable;
    logic       output_clock_enable;
    logic       timeout_clock_enable;
    logic       processing_clock_enable;
    logic       system_clock_enable;
    logic       locked_loop_enable;
    logic       range_compressor_enable;
    logic       sequencer_enable;
    logic       equaliser_enable;
  } pwrrg_ctrl_s;

  // ============================================================
  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pwrrg_apb_req_s;

endpackage : pwrrg_pkg

// file: hw/pwrrg_clkdiv.sv
/*
  enable-pulse divider: one pclk-wide pulse every div_i cycles while run_i.
  assumes: single pclk domain; div_i of zero or one gives a pulse each cycle.
*/
`timescale 1ns/1ns
module pwrrg_clkdiv #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  import pwrrg_pkg::*;

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  // ============================================================
  // counter
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run_i) begin
      // stopped divider restarts from zero, so first pulse is a full period
      cnt_next = '0;
    end else if (cnt_reg + W'(1) >= div_i) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule : pwrrg_clkdiv

// file: hw/pwrrg_thermal.sv
/*
  thermal output guard: latches an over-temperature trip and forces the
  audio outputs off while tripped.
  assumes: over_temp_i is synchronous to pclk; trip clears when the
  shutdown or sensor enable is cleared, or on soft reset unless a trip is set in the same cycle.
*/
`timescale 1ns/1ns
module pwrrg_thermal (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic soft_rst_i,
  input  wire logic shut_en_i,
  input  wire logic sense_en_i,
  input  wire logic over_temp_i,
  output logic      tripped_o
);
  import pwrrg_pkg::*;

  logic trip_reg;
  logic trip_next;

  // ============================================================
  // trip latch
  always_comb begin
    trip_next = trip_reg;
    if (shut_en_i && sense_en_i && over_temp_i) begin
      // set wins over soft reset: the enables come back set anyway
      trip_next = 1'b1;
    end else if (soft_rst_i || !shut_en_i || !sense_en_i) begin
      trip_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_reg <= 1'b0;
    end else begin
      trip_reg <= trip_next;
    end
  end

  assign tripped_o = trip_reg;

  tshut_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (shut_en_i && sense_en_i && over_temp_i) |=> tripped_o)
    else $error("thermal trip not taken");

endmodule : pwrrg_thermal

// file: test/pwrrg_regs_bench.sv
/*
  self-checking bench for the power enable and soft reset register bank.
  assumes: pwrrg_pkg compiled first; this bench is the only apb master.
*/
`timescale 1ns/1ns
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module pwrrg_regs_bench;
  import pwrrg_pkg::*;

  // ============================================================
  // settings and table
  localparam logic [15:0] ID_VAL = 16'h5A3C; // arbitrary value
  localparam int          NROW   = 11;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] rst;
    logic [31:0] ones;
    logic        err;
  } pwrrg_row_s;

  pwrrg_row_s     rows [NROW];
  logic           pclk;
  logic           presetn;
  pwrrg_apb_req_s apb_req;
  logic           pready;
  logic [31:0]    prdata;
  logic           pslverr;
  logic [3:0]     opdiv;
  logic           over_temp;
  pwrrg_ctrl_s    ctrl;
  pwrrg_ctrl_s    exp_c;
  logic           audio_ok;
  logic           dclk;
  logic           dclk_oe;
  logic           tclk;
  logic [31:0]    rd;
  logic           er;
  int             g;
  int             n_mismatch = 0;
  int             comparisons = 0;

  // short timeout divider keeps the pulse spacing checks quick
  pwrrg_regs #(.DEVICE_ID(ID_VAL), .TO_DIV(4), .OPDIV_W(4)) DUT (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .output_clock_divider(opdiv),
    .over_temp(over_temp), .ctrl(ctrl), .audio_out_allowed(audio_ok),
    .divided_output_clock(dclk), .divided_output_clock_oe(dclk_oe),
    .slow_timeout_clock(tclk));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ============================================================
  // bus and measurement tasks
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_mismatch++;
    r = prdata;
    e = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    // idle edge: no double assignment in one step, and ctrl has settled
    @(posedge pclk);
  endtask : xfer

  // cycles between two rising edges; zero when the signal stays quiet
  task automatic gap(input bit pick, output int gp);
    logic prev;
    logic cur;
    int   n;
    int   edges;
    n = 0;
    edges = 0;
    gp = 0;
    prev = pick ? tclk : dclk;
    while (edges < 2 && n < 50) begin
      @(negedge pclk);
      n++;
      cur = pick ? tclk : dclk;
      if (edges == 1) gp++;
      if (cur === 1'b1 && prev !== 1'b1) edges++;
      prev = cur;
    end
    if (edges < 2) gp = 0;
    @(posedge pclk);
  endtask : gap

  task automatic pulse_settle();
    over_temp <= 1'b1;
    @(posedge pclk);
    over_temp <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : pulse_settle

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end

  // ============================================================
  // main sequence
  initial begin
    apb_req = '0;
    presetn = 1'b0;
    over_temp = 1'b0;
    opdiv = 4'h2;
    rows = '{
      '{12'h010, 32'h0000_0000, 32'h0000_0006, 1'b0},
      '{12'h014, 32'h0000_0000, 32'h0000_0002, 1'b0},
      '{12'h02C, 32'h0000_0180, 32'h0000_0197, 1'b0},
      '{12'h038, 32'h0000_0000, 32'h0000_0027, 1'b0},
      '{12'h040, 32'h0000_0000, 32'h0000_0001, 1'b0},
      '{12'h080, 32'h0000_0000, 32'h0000_8000, 1'b0},
      '{12'h098, 32'h0000_0000, 32'h0000_8000, 1'b0},
      '{12'h0A8, 32'h0000_0000, 32'h0000_0001, 1'b0},
      '{12'h008, 32'h0000_0000, 32'h0000_0000, 1'b1},
      '{12'h011, 32'h0000_0000, 32'h0000_0000, 1'b1},
      '{12'h410, 32'h0000_0000, 32'h0000_0000, 1'b1}};
    exp_c = '0;
    exp_c.thermal_shutdown_enable = 1'b1;
    exp_c.thermal_sensor_enable = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHECK(ctrl, exp_c)
    `CHECK({audio_ok, dclk, dclk_oe, tclk}, 4'b1000)
    for (int i = 0; i < NROW; i++) begin
      xfer(1'b0, rows[i].a, 32'h0000_0000, rd, er);
      `CHECK(rd, rows[i].rst)
    end
    // mid-rail row precedes the bias row, so bias never runs without it
    for (int i = 0; i < NROW; i++) begin
      xfer(1'b1, rows[i].a, 32'hFFFF_FFFF, rd, er);
      `CHECK(er, rows[i].err)
      xfer(1'b0, rows[i].a, 32'h0000_0000, rd, er);
      `CHECK({rd, er}, {rows[i].ones, rows[i].err})
    end
    `CHECK(ctrl, pwrrg_ctrl_s'('1))

    // soft reset with arbitrary data, then identification read
    xfer(1'b1, 12'h000, 32'h0000_1234, rd, er);
    `CHECK(ctrl, exp_c)
    for (int i = 0; i < NROW; i++) begin
      xfer(1'b0, rows[i].a, 32'h0000_0000, rd, er);
      `CHECK(rd, rows[i].rst)
    end
    xfer(1'b0, 12'h000, 32'h0000_0000, rd, er);
    `CHECK(rd, {16'h0000, ID_VAL})

    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 12'h010, {29'h0, 2'(c), 1'b0}, rd, er);
      `CHECK(ctrl.midrail_divider_select, pwrrg_mid_e'(c))
    end

    // thermal trip latches, clears with the sensor, needs both enables
    xfer(1'b1, 12'h02C, 32'h0000_0197, rd, er);
    pulse_settle();
    `CHECK({audio_ok, ctrl.line_output_enable, ctrl.speaker_output_enable}, 3'b000)
    @(posedge pclk);
    xfer(1'b1, 12'h02C, 32'h0000_0117, rd, er);
    @(negedge pclk);
    `CHECK(audio_ok, 1'b1)
    @(posedge pclk);
    pulse_settle();
    `CHECK(audio_ok, 1'b1)
    @(posedge pclk);
    xfer(1'b1, 12'h02C, 32'h0000_0097, rd, er);
    pulse_settle();
    `CHECK(audio_ok, 1'b1)
    @(posedge pclk);
    xfer(1'b1, 12'h02C, 32'h0000_0197, rd, er);
    pulse_settle();
    `CHECK(audio_ok, 1'b0)
    @(posedge pclk);
    xfer(1'b1, 12'h000, 32'h0000_0000, rd, er);
    @(negedge pclk);
    `CHECK({audio_ok, ctrl}, {1'b1, exp_c})
    @(posedge pclk);

    // output clock half-period 2 and timeout period 4: both rise every 4
    xfer(1'b1, 12'h038, 32'h0000_0024, rd, er);
    `CHECK(dclk_oe, 1'b1)
    gap(1'b0, g);
    `CHECK(g, 4)
    gap(1'b1, g);
    `CHECK(g, 4)
    // unused clocks go back off once the measurement is done
    xfer(1'b1, 12'h038, 32'h0000_0000, rd, er);
    // output clock register drops one edge after the enable
    @(negedge pclk);
    `CHECK({dclk_oe, dclk}, 2'b00)
    gap(1'b0, g);
    `CHECK(g, 0)
    gap(1'b1, g);
    `CHECK(g, 0)

    // reset in mid-run with outputs enabled, then first request at once
    xfer(1'b1, 12'h02C, 32'h0000_0017, rd, er);
    presetn <= 1'b0;
    @(posedge pclk);
    `CHECK({audio_ok, ctrl}, {1'b1, exp_c})
    presetn <= 1'b1;
    xfer(1'b0, 12'h02C, 32'h0000_0000, rd, er);
    `CHECK({rd, er}, {32'h0000_0180, 1'b0})
    finish_test();
  end

endmodule : pwrrg_regs_bench
